//--- rtl/asm_defines.svh
/*
 * Constants for the amplifier switch matrix control: reference-field codes,
 * reset values and gain-field codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH

`define ASM_REF_NONE 2'h0
`define ASM_REF_HIGH 2'h1
`define ASM_REF_MID 2'h2
`define ASM_REF_LOW 2'h3
`define ASM_RST_PIN_SEL 1'h1
`define ASM_RST_BIT 1'h0
`define ASM_RST_REF 2'h0
`define ASM_RST_GAIN 3'h0
`define ASM_GAIN_UNITY 6'h01
`define ASM_GAIN_STEP 6'h08

`endif

//--- rtl/asm_pkg.sv
/*
 * Types shared by the amplifier switch matrix control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package asm_pkg;
    // Function assigned to one shared port pin
    typedef enum logic [1:0] {
        ASM_PIN_GPIO,
        ASM_PIN_NONINV_IN,
        ASM_PIN_INV_IN,
        ASM_PIN_AMP_OUT
    } asm_pin_func_t;
endpackage

//--- rtl/asm_switch_ctrl.sv
/*
 * Switch matrix control for two on-chip amplifiers: holds the software
 * control bits, applies hardware overrides, drives switch enables and
 * the function select of six shared port pins.
 * Assumes write strobes come from logic on clk_sys, one cycle wide.
 */
`timescale 1ns/100ps
`include "asm_defines.svh"

// Summary of operation
// - sw7_c follows amp-one-to-comparator enable
// - Noninv pin select forces reference field 00
// - Amp one disabled keeps sw6_c open
// - Pin selects and reference field drive amp-one switches
// - Amp-one feedback only while enabled, cleared otherwise
// - Amp-one pins: GPIO, input or output
// - Gain enable closes sw6_d/sw7_d; feedback closes sw9_d
// - Amp two disabled opens sw6_d, sw7_d, sw9_d
// - Amp-two pin, reference, amp-one path switches
// - Amp-two pins: GPIO, input or output
// - Gain plus inverting pin bypasses res_in
// - Gain field encodes one, then seven steps of eight
// - Amp two disable clears gain and feedback
// - Amp-two pin selects clear conflicting sources
module asm_switch_ctrl
    import asm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic amp1Wr,
    input wire logic amp1ToComparatorEnIn,
    input wire logic amp1FeedbackEnIn,
    input wire logic [1:0] amp1RefSelectIn,
    input wire logic amp1NoninvPinSelIn,
    input wire logic amp1InvPinSelIn,
    input wire logic amp1EnableIn,
    input wire logic amp2Wr,
    input wire logic amp2FeedbackEnIn,
    input wire logic [1:0] amp2RefSelectIn,
    input wire logic amp2NoninvPinSelIn,
    input wire logic amp2InvPinSelIn,
    input wire logic amp2EnableIn,
    input wire logic amp2GainWr,
    input wire logic amp1ToAmp2InvIn,
    input wire logic amp1ToAmp2NoninvIn,
    input wire logic amp2GainEnableIn,
    input wire logic [2:0] amp2GainFieldIn,
    output logic amp1ToComparatorEn,
    output logic amp1FeedbackEn,
    output logic [1:0] amp1RefSelect,
    output logic amp1NoninvPinSel,
    output logic amp1InvPinSel,
    output logic amp1Enable,
    output logic amp2FeedbackEn,
    output logic [1:0] amp2RefSelect,
    output logic amp2NoninvPinSel,
    output logic amp2InvPinSel,
    output logic amp2Enable,
    output logic amp1ToAmp2Inv,
    output logic amp1ToAmp2Noninv,
    output logic amp2GainEnable,
    output logic [2:0] amp2GainField,
    output logic [5:0] amp2Gain,
    output logic sw4C,
    output logic sw5C,
    output logic sw6C,
    output logic sw7C,
    output logic sw8C,
    output logic sw9C,
    output logic sw10C,
    output logic sw4D,
    output logic sw5D,
    output logic sw6D,
    output logic sw7D,
    output logic sw8D,
    output logic sw9D,
    output logic sw11D,
    output logic sw12D,
    output logic sw13D,
    output logic sw14D,
    output logic resInBypass,
    output asm_pin_func_t portABit2Func,
    output asm_pin_func_t portABit3Func,
    output asm_pin_func_t portABit4Func,
    output asm_pin_func_t portABit5Func,
    output asm_pin_func_t portABit6Func,
    output asm_pin_func_t portABit7Func
);

    logic next_amp1ToComparatorEn;
    logic next_amp1FeedbackEn;
    logic [1:0] next_amp1RefSelect;
    logic next_amp1NoninvPinSel;
    logic next_amp1InvPinSel;
    logic next_amp1Enable;
    logic next_amp2FeedbackEn;
    logic [1:0] next_amp2RefSelect;
    logic next_amp2NoninvPinSel;
    logic next_amp2InvPinSel;
    logic next_amp2Enable;
    logic next_amp1ToAmp2Inv;
    logic next_amp1ToAmp2Noninv;
    logic next_amp2GainEnable;
    logic [2:0] next_amp2GainField;

    // Next register values; overrides act on the value being stored so a
    // read-back already shows the forced bits, not only the switches.
    // Each write strobe loads its whole group at once. The three groups
    // load independently, but the amp-two bits override the gain group,
    // so a gain write must come in the same cycle as or after the amp-two write.
    // The overrides are worked out on the post-write values of every
    // group. A disable of amp two, for example, also clears a gain enable
    // that a gain write stores in the same cycle. Software then never sees
    // a stored bit that the switches would ignore.
    // Trade-off: clearing the stored bits costs a little logic in the
    // next-value path. It saves software a read-modify-write to find
    // out which bits the hardware has dropped.
    always_comb begin
        next_amp1ToComparatorEn = amp1ToComparatorEn;
        next_amp1FeedbackEn = amp1FeedbackEn;
        next_amp1RefSelect = amp1RefSelect;
        next_amp1NoninvPinSel = amp1NoninvPinSel;
        next_amp1InvPinSel = amp1InvPinSel;
        next_amp1Enable = amp1Enable;
        next_amp2FeedbackEn = amp2FeedbackEn;
        next_amp2RefSelect = amp2RefSelect;
        next_amp2NoninvPinSel = amp2NoninvPinSel;
        next_amp2InvPinSel = amp2InvPinSel;
        next_amp2Enable = amp2Enable;
        next_amp1ToAmp2Inv = amp1ToAmp2Inv;
        next_amp1ToAmp2Noninv = amp1ToAmp2Noninv;
        next_amp2GainEnable = amp2GainEnable;
        next_amp2GainField = amp2GainField;
        if (amp1Wr) begin
            next_amp1ToComparatorEn = amp1ToComparatorEnIn;
            next_amp1FeedbackEn = amp1FeedbackEnIn;
            next_amp1RefSelect = amp1RefSelectIn;
            next_amp1NoninvPinSel = amp1NoninvPinSelIn;
            next_amp1InvPinSel = amp1InvPinSelIn;
            next_amp1Enable = amp1EnableIn;
        end
        if (amp2Wr) begin
            next_amp2FeedbackEn = amp2FeedbackEnIn;
            next_amp2RefSelect = amp2RefSelectIn;
            next_amp2NoninvPinSel = amp2NoninvPinSelIn;
            next_amp2InvPinSel = amp2InvPinSelIn;
            next_amp2Enable = amp2EnableIn;
        end
        if (amp2GainWr) begin
            next_amp1ToAmp2Inv = amp1ToAmp2InvIn;
            next_amp1ToAmp2Noninv = amp1ToAmp2NoninvIn;
            next_amp2GainEnable = amp2GainEnableIn;
            next_amp2GainField = amp2GainFieldIn;
        end
        // Hardware overrides come last so they win over any write
        if (next_amp1NoninvPinSel) begin
            next_amp1RefSelect = `ASM_REF_NONE;
        end
        if (!next_amp1Enable) begin
            next_amp1FeedbackEn = `ASM_RST_BIT;
        end
        if (!next_amp2Enable) begin
            next_amp2GainEnable = `ASM_RST_BIT;
            next_amp2FeedbackEn = `ASM_RST_BIT;
        end
        if (next_amp2NoninvPinSel) begin
            next_amp1ToAmp2Noninv = `ASM_RST_BIT;
            next_amp2RefSelect = `ASM_REF_NONE;
        end
        if (next_amp2InvPinSel) begin
            next_amp1ToAmp2Inv = `ASM_RST_BIT;
        end
    end

    // Control register bank, reset to power-on values
    // Both pin selects of each amplifier come up set, so that each amplifier
    // starts with its inputs on the port pins. Enables come up clear, so
    // every pin stays general I/O until software turns an amplifier on.
    // The reset branch loads constants only; the next values are taken
    // on every edge, since there is no clock enable.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            amp1ToComparatorEn <= `ASM_RST_BIT;
            amp1FeedbackEn <= `ASM_RST_BIT;
            amp1RefSelect <= `ASM_RST_REF;
            amp1NoninvPinSel <= `ASM_RST_PIN_SEL;
            amp1InvPinSel <= `ASM_RST_PIN_SEL;
            amp1Enable <= `ASM_RST_BIT;
            amp2FeedbackEn <= `ASM_RST_BIT;
            amp2RefSelect <= `ASM_RST_REF;
            amp2NoninvPinSel <= `ASM_RST_PIN_SEL;
            amp2InvPinSel <= `ASM_RST_PIN_SEL;
            amp2Enable <= `ASM_RST_BIT;
            amp1ToAmp2Inv <= `ASM_RST_BIT;
            amp1ToAmp2Noninv <= `ASM_RST_BIT;
            amp2GainEnable <= `ASM_RST_BIT;
            amp2GainField <= `ASM_RST_GAIN;
        end else begin
            amp1ToComparatorEn <= next_amp1ToComparatorEn;
            amp1FeedbackEn <= next_amp1FeedbackEn;
            amp1RefSelect <= next_amp1RefSelect;
            amp1NoninvPinSel <= next_amp1NoninvPinSel;
            amp1InvPinSel <= next_amp1InvPinSel;
            amp1Enable <= next_amp1Enable;
            amp2FeedbackEn <= next_amp2FeedbackEn;
            amp2RefSelect <= next_amp2RefSelect;
            amp2NoninvPinSel <= next_amp2NoninvPinSel;
            amp2InvPinSel <= next_amp2InvPinSel;
            amp2Enable <= next_amp2Enable;
            amp1ToAmp2Inv <= next_amp1ToAmp2Inv;
            amp1ToAmp2Noninv <= next_amp1ToAmp2Noninv;
            amp2GainEnable <= next_amp2GainEnable;
            amp2GainField <= next_amp2GainField;
        end
    end

    // Amp-one switches decode straight from the stored bits, so they
    // follow a write at the next edge with no extra stage
    // The reference switches are also gated by the pin select, although
    // the stored field is already forced to zero. This keeps the pin
    // and an internal reference from meeting on the same node, should a
    // later change drop the override on the stored field.
    // The feedback switch is gated by the enable for the same reason.
    always_comb begin
        sw7C = amp1ToComparatorEn;
        sw4C = amp1NoninvPinSel;
        sw5C = amp1InvPinSel;
        sw6C = amp1Enable & amp1FeedbackEn;
        sw10C = (amp1RefSelect == `ASM_REF_HIGH) & ~amp1NoninvPinSel;
        sw9C = (amp1RefSelect == `ASM_REF_MID) & ~amp1NoninvPinSel;
        sw8C = (amp1RefSelect == `ASM_REF_LOW) & ~amp1NoninvPinSel;
    end

    // Amp-two switches; enable gates the feedback and gain network
    // The paths from amp one are blocked while the matching pin select is
    // set, so the amp-one output never shorts an external input pin.
    // The reference switches share the non-inverting node with the pin
    // and are blocked by its select in the same way.
    // The input resistor is bypassed only when the gain network is in use
    // and the inverting input comes straight from its pin.
    always_comb begin
        sw6D = amp2Enable & amp2GainEnable;
        sw7D = amp2Enable & amp2GainEnable;
        sw9D = amp2Enable & amp2FeedbackEn;
        sw4D = amp2NoninvPinSel;
        sw5D = amp2InvPinSel;
        sw11D = amp1ToAmp2Noninv & ~amp2NoninvPinSel;
        sw8D = amp1ToAmp2Inv & ~amp2InvPinSel;
        sw12D = (amp2RefSelect == `ASM_REF_HIGH) & ~amp2NoninvPinSel;
        sw13D = (amp2RefSelect == `ASM_REF_MID) & ~amp2NoninvPinSel;
        sw14D = (amp2RefSelect == `ASM_REF_LOW) & ~amp2NoninvPinSel;
        resInBypass = amp2Enable & amp2GainEnable & amp2InvPinSel;
    end

    // Gain: code 0 is unity, otherwise eight per step up to 56
    // The product is cut to six bits on purpose; the largest code gives
    // 56, so no gain value is lost by the cut.
    always_comb begin
        if (amp2GainField == `ASM_RST_GAIN) begin
            amp2Gain = `ASM_GAIN_UNITY;
        end else begin
            amp2Gain = 6'({3'h0, amp2GainField} * `ASM_GAIN_STEP);
        end
    end

    // Pin functions; a disabled amplifier hands all its pins back to GPIO
    // The output pin is claimed as soon as the amplifier is enabled.
    // Each input pin is claimed only while its select is set, except that gain mode
    // also claims the amp-two inverting pin. A user who leaves a select set while
    // the amplifier is off therefore keeps the pin as general I/O until the amplifier is enabled again.
    // Pin functions come from flip-flops through this decode only, so
    // they change in the same cycle as the switch enables.
    always_comb begin
        portABit2Func = ASM_PIN_GPIO;
        portABit3Func = ASM_PIN_GPIO;
        portABit4Func = ASM_PIN_GPIO;
        portABit5Func = ASM_PIN_GPIO;
        portABit6Func = ASM_PIN_GPIO;
        portABit7Func = ASM_PIN_GPIO;
        if (amp1Enable) begin
            portABit4Func = ASM_PIN_AMP_OUT;
            if (amp1NoninvPinSel) begin
                portABit2Func = ASM_PIN_NONINV_IN;
            end
            if (amp1InvPinSel) begin
                portABit3Func = ASM_PIN_INV_IN;
            end
        end
        if (amp2Enable) begin
            portABit7Func = ASM_PIN_AMP_OUT;
            if (amp2NoninvPinSel) begin
                portABit5Func = ASM_PIN_NONINV_IN;
            end
            // Gain mode needs the inverting pin even without its select
            if (amp2InvPinSel | amp2GainEnable) begin
                portABit6Func = ASM_PIN_INV_IN;
            end
        end
    end

endmodule

//--- test/asm_switch_ctrl_asserts.sv
/*
 * Concurrent checks on the amplifier switch matrix control ports.
 * Assumes one clk_sys domain, active-low async rst_n, bound by name.
 */
`timescale 1ns/100ps
module asm_switch_ctrl_asserts
    import asm_pkg::*;
(
    input wire logic clk_sys, rst_n, amp1Wr, amp1ToComparatorEnIn, amp2Wr, amp2EnableIn,
    input wire logic amp2GainWr, amp2GainEnableIn, amp1FeedbackEn, amp1NoninvPinSel, amp1Enable,
    input wire logic amp2FeedbackEn, amp2NoninvPinSel, amp2InvPinSel, amp2Enable, amp1ToAmp2Noninv,
    input wire logic amp2GainEnable, sw6C, sw7C, sw8C, sw9C, sw10C, sw6D, sw7D, sw9D, sw11D, resInBypass,
    input wire logic [1:0] amp1RefSelect, amp2RefSelect,
    input wire logic [2:0] amp2GainFieldIn,
    input wire logic [5:0] amp2Gain,
    input wire asm_pin_func_t portABit2Func, portABit3Func, portABit4Func, portABit6Func
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Steps of the amp-two disable and gain-enable writes
    sequence sA2Off; amp2Wr && !amp2EnableIn; endsequence
    sequence sSw2Open; !sw6D && !sw7D && !sw9D && !amp2GainEnable && !amp2FeedbackEn; endsequence
    sequence sGainOn; amp2GainWr && amp2GainEnableIn && amp2Enable && !amp2Wr; endsequence
    AST_CMP_PATH: assert property (amp1Wr |=> sw7C == $past(amp1ToComparatorEnIn))
        else $error("comparator path switch wrong");
    AST_REF1_CLEAR: assert property (amp1NoninvPinSel |-> amp1RefSelect == 2'h0 && !sw8C && !sw9C && !sw10C)
        else $error("amp one reference not cleared");
    AST_FB1_OFF: assert property (!amp1Enable |-> !sw6C && !amp1FeedbackEn)
        else $error("amp one feedback active while off");
    AST_REF1_SW: assert property (amp1RefSelect == 2'h2 |-> sw9C && !sw8C && !sw10C)
        else $error("amp one reference switch wrong");
    AST_PIN1_GPIO: assert property (!amp1Enable |-> portABit2Func == ASM_PIN_GPIO && portABit3Func == ASM_PIN_GPIO
        && portABit4Func == ASM_PIN_GPIO)
        else $error("amp one pins not released");
    AST_GAIN_SW: assert property (sGainOn |=> sw6D && sw7D)
        else $error("gain switches not closed");
    AST_A2_OFF: assert property (sA2Off |=> sSw2Open)
        else $error("amp two switches not opened");
    AST_BYPASS: assert property (amp2Enable && amp2GainEnable && amp2InvPinSel
        |-> resInBypass && portABit6Func == ASM_PIN_INV_IN)
        else $error("input resistor not bypassed");
    AST_GAIN_CODE: assert property (amp2GainWr |=> amp2Gain == ($past(amp2GainFieldIn) == 3'h0 ? 6'h01
        : {$past(amp2GainFieldIn), 3'h0}))
        else $error("gain decode wrong");
    AST_A2P_CLEAR: assert property (amp2NoninvPinSel |-> !amp1ToAmp2Noninv && !sw11D && amp2RefSelect == 2'h0)
        else $error("amp two sources not cleared");
    AST_HOLD: assert property (!amp1Wr && !amp2Wr && !amp2GainWr
        |=> $stable({sw6C, sw7C, sw8C, sw6D, sw9D, amp2Gain}))
        else $error("outputs moved without a write");
endmodule

//--- test/asm_switch_net.sv
/*
 * Model of the shared port pins: flags each pin claimed by the analog side.
 * Assumes six two-bit pin functions, pin two in the lowest pair.
 */
`timescale 1ns/100ps
module asm_switch_net (
    input wire logic [11:0] pinFunc,
    output logic [5:0] analogPin
);
    // Any function but GPIO takes the pin away from port logic
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            analogPin[i] = pinFunc[2*i +: 2] != 2'h0;
        end
    end
endmodule

//--- test/test_amp_switch_matrix_control.sv
/*
 * Random and corner writes to the switch matrix control with a bench model.
 * Assumes the design package and checker files are compiled first.
 */
`timescale 1ns/100ps
module test_amp_switch_matrix_control;
    import asm_pkg::*;
    logic clk_sys, rst_n, w1, w2, wg;
    logic [6:0] d1, q1, s1, sc, pa;
    logic [5:0] d2, q2, s2, dg, qg, sg, gn, an, pb, pg;
    logic [10:0] sd;
    logic [11:0] pf, ep;
    logic [2:0] pw;
    int n_fail, comparisons;
    asm_switch_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .amp1Wr(w1), .amp2Wr(w2), .amp2GainWr(wg),
        .amp1ToComparatorEnIn(d1[6]), .amp1FeedbackEnIn(d1[5]), .amp1RefSelectIn(d1[4:3]),
        .amp1NoninvPinSelIn(d1[2]), .amp1InvPinSelIn(d1[1]), .amp1EnableIn(d1[0]),
        .amp2FeedbackEnIn(d2[5]), .amp2RefSelectIn(d2[4:3]), .amp2NoninvPinSelIn(d2[2]),
        .amp2InvPinSelIn(d2[1]), .amp2EnableIn(d2[0]), .amp1ToAmp2InvIn(dg[5]), .amp1ToAmp2NoninvIn(dg[4]),
        .amp2GainEnableIn(dg[3]), .amp2GainFieldIn(dg[2:0]),
        .amp1ToComparatorEn(q1[6]), .amp1FeedbackEn(q1[5]), .amp1RefSelect(q1[4:3]),
        .amp1NoninvPinSel(q1[2]), .amp1InvPinSel(q1[1]), .amp1Enable(q1[0]),
        .amp2FeedbackEn(q2[5]), .amp2RefSelect(q2[4:3]), .amp2NoninvPinSel(q2[2]),
        .amp2InvPinSel(q2[1]), .amp2Enable(q2[0]), .amp1ToAmp2Inv(qg[5]), .amp1ToAmp2Noninv(qg[4]),
        .amp2GainEnable(qg[3]), .amp2GainField(qg[2:0]), .amp2Gain(gn),
        .sw4C(sc[0]), .sw5C(sc[1]), .sw6C(sc[2]), .sw7C(sc[3]), .sw8C(sc[4]), .sw9C(sc[5]), .sw10C(sc[6]),
        .sw4D(sd[0]), .sw5D(sd[1]), .sw6D(sd[2]), .sw7D(sd[3]), .sw8D(sd[4]), .sw9D(sd[5]),
        .sw11D(sd[6]), .sw12D(sd[7]), .sw13D(sd[8]), .sw14D(sd[9]), .resInBypass(sd[10]),
        .portABit2Func(pf[1:0]), .portABit3Func(pf[3:2]), .portABit4Func(pf[5:4]),
        .portABit5Func(pf[7:6]), .portABit6Func(pf[9:8]), .portABit7Func(pf[11:10]));
    asm_switch_net u_net (.pinFunc(pf), .analogPin(an));
    // Free-running 20 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] fn(input logic on, input asm_pin_func_t f);
        fn = on ? f : ASM_PIN_GPIO;
    endfunction
    // Reset also restores the bench model to the documented reset state
    task automatic rst(input int n);
        @(posedge clk_sys);
        rst_n <= 1'h0;
        {w1, w2, wg} <= 3'h0;
        repeat (n) @(posedge clk_sys);
        rst_n <= 1'h1;
        {pw, s1, s2, sg} = {3'h0, 7'h06, 6'h06, 6'h00};
    endtask
    // Model takes the previous write at this edge, then all outputs are compared mid-cycle
    task automatic cyc(input logic [2:0] w, input logic [6:0] a, input logic [5:0] b, input logic [5:0] g);
        @(posedge clk_sys);
        if (pw[2]) s1 = pa;
        if (pw[1]) s2 = pb;
        if (pw[0]) sg = pg;
        if (s1[2]) s1[4:3] = 2'h0;
        if (!s1[0]) s1[5] = 1'h0;
        if (!s2[0]) {s2[5], sg[3]} = 2'h0;
        if (s2[2]) {s2[4:3], sg[4]} = 3'h0;
        if (s2[1]) sg[5] = 1'h0;
        {w1, w2, wg} <= w;
        d1 <= a;
        d2 <= b;
        dg <= g;
        {pw, pa, pb, pg} = {w, a, b, g};
        ep = {fn(s2[0], ASM_PIN_AMP_OUT), fn(s2[0] & (s2[1] | sg[3]), ASM_PIN_INV_IN),
            fn(s2[0] & s2[2], ASM_PIN_NONINV_IN), fn(s1[0], ASM_PIN_AMP_OUT), fn(s1[0] & s1[1], ASM_PIN_INV_IN),
            fn(s1[0] & s1[2], ASM_PIN_NONINV_IN)};
        @(negedge clk_sys);
        check(q1, s1);
        check(q2, s2);
        check(qg, sg);
        check(sc, {s1[4:3] == 2'h1, s1[4:3] == 2'h2, s1[4:3] == 2'h3, s1[6], s1[5], s1[1], s1[2]});
        check(sd, {sg[3] & s2[1], s2[4:3] == 2'h3, s2[4:3] == 2'h2, s2[4:3] == 2'h1, sg[4], s2[5], sg[5],
            sg[3], sg[3], s2[1], s2[2]});
        check(gn, (sg[2:0] == 3'h0) ? 6'h01 : {sg[2:0], 3'h0});
        check(pf[5:0], ep[5:0]);
        check(pf[11:6], ep[11:6]);
        check(an, {|ep[11:10], |ep[9:8], |ep[7:6], |ep[5:4], |ep[3:2], |ep[1:0]});
    endtask
    task automatic end_sim;
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Corner writes first, then random traffic around a mid-run reset
    initial begin
        {rst_n, w1, w2, wg, d1, d2, dg} = '0;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(32'h69F2));
        rst(16);
        cyc(3'h3, 7'h00, 6'h3E, 6'h3F);
        cyc(3'h7, 7'h7F, 6'h01, 6'h3F);
        cyc(3'h5, 7'h5B, 6'h39, 6'h0F);
        for (int k = 0; k < 800; k++) begin
            if (k == 400) rst(2);
            cyc(3'($urandom), 7'($urandom), 6'($urandom), 6'($urandom));
        end
        end_sim;
    end
endmodule
bind asm_switch_ctrl asm_switch_ctrl_asserts u_chk (.*);
